// *** hw/ssx_pkg.sv ***
// ssx_pkg: shared types and constants for the subtract/swap/xor execution block
package ssx_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;

    // operation codes presented by decode
    typedef enum logic [3:0] {
        SSX_OP_NOP          = 4'h0,
        SSX_OP_SUB_IMM      = 4'h1,
        SSX_OP_SUB_REG      = 4'h2,
        SSX_OP_SUB_REG_BRW  = 4'h3,
        SSX_OP_NIBBLE_EXCH  = 4'h4,
        SSX_OP_LOAD_DIR     = 4'h5,
        SSX_OP_XOR_IMM      = 4'h6,
        SSX_OP_XOR_REG      = 4'h7,
        SSX_OP_SLEEP        = 4'h8
    } ssx_op_t;

    // direction register selectors
    localparam logic [2:0] DIR_SEL_A = 3'h5;
    localparam logic [2:0] DIR_SEL_B = 3'h6;
    localparam logic [2:0] DIR_SEL_C = 3'h7;

    // destination bit encoding
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_REG = 1'b1;

    // reset values
    localparam logic [7:0] ACC_RST      = 8'h00;
    localparam logic [7:0] DIR_RST      = 8'hFF;
    localparam logic [7:0] WDT_CLEAR    = 8'h00;
    localparam logic [7:0] PRESC_CLEAR  = 8'h00;
    localparam logic       TO_RST       = 1'b1;
    localparam logic       PD_RST       = 1'b1;

    // low nibble field
    localparam int NIB_HI = 3;
    localparam int NIB_W  = 4;

    // one instruction issued by decode
    typedef struct packed {
        logic                valid;
        ssx_op_t             op;
        logic [DATA_W-1:0]   imm;
        logic [ADDR_W-1:0]   addr;
        logic                dest;
    } ssx_instr_t;

    // file-register write-back
    typedef struct packed {
        logic                we;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } ssx_fwrite_t;

    // status flags
    typedef struct packed {
        logic carry;
        logic digit_carry;
        logic zero;
    } ssx_flags_t;

    // subtractor result
    typedef struct packed {
        logic [DATA_W-1:0] diff;
        logic              carry;
        logic              digit_carry;
    } ssx_sub_t;

endpackage : ssx_pkg

// *** hw/ssx_subtractor.sv ***
// ssx_subtractor: 8-bit minuend minus subtrahend minus borrow, with carry outputs
`timescale 1ns/10ps

module ssx_subtractor
    import ssx_pkg::*;
(
    // operands
    input  wire logic [ssx_pkg::DATA_W-1:0] minuend,
    input  wire logic [ssx_pkg::DATA_W-1:0] subtrahend,
    input  wire logic                       borrow_in,
    // result
    output ssx_pkg::ssx_sub_t               result
);

    logic [ssx_pkg::NIB_W:0]  low_sum;
    logic [ssx_pkg::DATA_W:0] full_sum;

    // two's complement: a + ~b + carry_in, carry out is not-borrow
    always_comb
    begin
        low_sum  = {1'b0, minuend[NIB_HI:0]} + {1'b0, ~subtrahend[NIB_HI:0]}
                   + {{NIB_W{1'b0}}, ~borrow_in};
        full_sum = {1'b0, minuend} + {1'b0, ~subtrahend}
                   + {{DATA_W{1'b0}}, ~borrow_in};
        result.diff        = full_sum[DATA_W-1:0];
        result.carry       = full_sum[DATA_W];
        result.digit_carry = low_sum[NIB_W];
    end

endmodule : ssx_subtractor

// *** hw/ssx_exec.sv ***
// ssx_exec: execution datapath for subtract, nibble swap, xor, direction load, sleep
//
// Overview of operation
// - Subtract-from-immediate puts the immediate minus the accumulator into the accumulator.
// - Every subtract updates carry (clear on borrow), digit carry (low nibble) and zero.
// - Subtract-from-register computes the addressed file register minus the accumulator.
// - A destination bit of 0 sends the result to the accumulator, 1 to the file register.
// - Subtract-with-borrow also takes away the inverted carry flag as the borrow.
// - Sleep clears watchdog and prescaler, sets timeout, clears power-down, enters sleep.
// - Nibble exchange swaps the two halves of the source and leaves all flags alone.
// - Direction load copies the accumulator into port A, B or C direction for 5, 6 or 7.
// - Xor-with-immediate puts accumulator xor immediate in the accumulator, zero flag only.
// - Xor-with-register xors with the file register, routed by destination, zero only.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps

module ssx_exec
    import ssx_pkg::*;
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    // decoded instruction and file register read value
    input  ssx_pkg::ssx_instr_t             instr,
    input  wire logic [ssx_pkg::DATA_W-1:0] file_rdata,
    // wake from sleep (from the wake logic outside this block)
    input  wire logic                       wake,
    // file register write-back
    output ssx_pkg::ssx_fwrite_t            file_wr,
    // architectural state
    output logic [ssx_pkg::DATA_W-1:0]      acc,
    output ssx_pkg::ssx_flags_t             flags,
    output logic [ssx_pkg::DATA_W-1:0]      port_a_direction,
    output logic [ssx_pkg::DATA_W-1:0]      port_b_direction,
    output logic [ssx_pkg::DATA_W-1:0]      port_c_direction,
    // power status and sleep control
    output logic                            timeout_status_flag,
    output logic                            powerdown_status_flag,
    output logic [ssx_pkg::DATA_W-1:0]      watchdog_counter,
    output logic [ssx_pkg::DATA_W-1:0]      watchdog_prescaler,
    output logic                            sleep_active
);

    // ======================================================================
    // state
    // ======================================================================
    logic [DATA_W-1:0] acc_reg,    acc_next;
    ssx_flags_t        flags_reg,  flags_next;
    ssx_fwrite_t       fwr_reg,    fwr_next;
    logic              to_reg,     to_next;
    logic              pd_reg,     pd_next;
    logic [DATA_W-1:0] wdt_reg,    wdt_next;
    logic [DATA_W-1:0] presc_reg,  presc_next;
    logic              sleep_reg,  sleep_next;

    // ======================================================================
    // subtractor
    // ======================================================================
    logic [DATA_W-1:0] sub_minuend;
    logic              sub_borrow;
    ssx_sub_t          sub_res;

    always_comb
    begin
        sub_minuend = (instr.op == SSX_OP_SUB_IMM) ? instr.imm : file_rdata;
        // only the borrow form consumes carry; others subtract with no borrow
        sub_borrow  = (instr.op == SSX_OP_SUB_REG_BRW) ? ~flags_reg.carry
                                                      : 1'b0;
    end

    ssx_subtractor u_sub (
        .minuend    (sub_minuend),
        .subtrahend (acc_reg),
        .borrow_in  (sub_borrow),
        .result     (sub_res)
    );

    // ======================================================================
    // decode
    // ======================================================================
    logic              take;
    logic [DATA_W-1:0] result;
    logic              write_result;
    logic              use_dest;
    logic              to_file;
    logic              sets_arith;
    logic              sets_zero;

    // instructions are ignored while the core sleeps
    assign take = instr.valid && !sleep_reg;

    always_comb
    begin
        result       = '0;
        write_result = 1'b0;
        use_dest     = 1'b0;
        sets_arith   = 1'b0;
        sets_zero    = 1'b0;
        unique case (instr.op)
            SSX_OP_SUB_IMM:
            begin
                result       = sub_res.diff;
                write_result = 1'b1;
                sets_arith   = 1'b1;
                sets_zero    = 1'b1;
            end
            SSX_OP_SUB_REG, SSX_OP_SUB_REG_BRW:
            begin
                result       = sub_res.diff;
                write_result = 1'b1;
                use_dest     = 1'b1;
                sets_arith   = 1'b1;
                sets_zero    = 1'b1;
            end
            SSX_OP_NIBBLE_EXCH:
            begin
                // flags deliberately untouched
                result       = {file_rdata[NIB_HI:0],
                                file_rdata[DATA_W-1:NIB_W]};
                write_result = 1'b1;
                use_dest     = 1'b1;
            end
            SSX_OP_XOR_IMM:
            begin
                result       = acc_reg ^ instr.imm;
                write_result = 1'b1;
                sets_zero    = 1'b1;
            end
            SSX_OP_XOR_REG:
            begin
                result       = acc_reg ^ file_rdata;
                write_result = 1'b1;
                use_dest     = 1'b1;
                sets_zero    = 1'b1;
            end
            // direction load and sleep act in their own groups below
            SSX_OP_LOAD_DIR, SSX_OP_SLEEP, SSX_OP_NOP:
            begin
                result = '0;
            end
            default:
            begin
                result = '0;
            end
        endcase
    end

    // destination bit 1 sends the result back to the file register
    assign to_file = use_dest && (instr.dest == DEST_REG);

    // ======================================================================
    // accumulator
    // ======================================================================
    always_comb
    begin
        acc_next = acc_reg;
        if (take && write_result && !to_file)
        begin
            acc_next = result;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc_reg <= ACC_RST;
        end
        else
        begin
            acc_reg <= acc_next;
        end
    end

    // ======================================================================
    // status flags
    // ======================================================================
    always_comb
    begin
        flags_next = flags_reg;
        if (take && sets_arith)
        begin
            flags_next.carry       = sub_res.carry;
            flags_next.digit_carry = sub_res.digit_carry;
        end
        if (take && sets_zero)
        begin
            flags_next.zero = (result == '0);
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flags_reg <= '0;
        end
        else
        begin
            flags_reg <= flags_next;
        end
    end

    // ======================================================================
    // file register write-back
    // ======================================================================
    always_comb
    begin
        // strobe lasts one cycle; address and data drop back with it
        fwr_next = '0;
        if (take && write_result && to_file)
        begin
            fwr_next.we   = 1'b1;
            fwr_next.addr = instr.addr;
            fwr_next.data = result;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fwr_reg <= '0;
        end
        else
        begin
            fwr_reg <= fwr_next;
        end
    end

    // ======================================================================
    // port direction registers, one per selector
    // ======================================================================
    localparam int DIR_N = int'(DIR_SEL_C) - int'(DIR_SEL_A) + 1;

    logic dir_load;

    assign dir_load = take && (instr.op == SSX_OP_LOAD_DIR);

    generate
        for (genvar i = 0; i < DIR_N; i++)
        begin : g_dir
            logic [DATA_W-1:0] dir_reg;
            logic [DATA_W-1:0] dir_next;

            // full address compare: selectors outside 5..7 load nothing
            always_comb
            begin
                dir_next = dir_reg;
                if (dir_load && instr.addr == ADDR_W'(int'(DIR_SEL_A) + i))
                begin
                    dir_next = acc_reg;
                end
            end

            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    dir_reg <= DIR_RST;
                end
                else
                begin
                    dir_reg <= dir_next;
                end
            end
        end
    endgenerate

    // ======================================================================
    // power status and sleep
    // ======================================================================
    always_comb
    begin
        to_next    = to_reg;
        pd_next    = pd_reg;
        wdt_next   = wdt_reg;
        presc_next = presc_reg;
        // wake only ends a sleep; a sleep issued in that cycle is not taken, so the core wakes
        sleep_next = sleep_reg && !wake;
        if (take && (instr.op == SSX_OP_SLEEP))
        begin
            wdt_next   = WDT_CLEAR;
            presc_next = PRESC_CLEAR;
            to_next    = 1'b1;
            pd_next    = 1'b0;
            sleep_next = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            to_reg    <= TO_RST;
            pd_reg    <= PD_RST;
            wdt_reg   <= WDT_CLEAR;
            presc_reg <= PRESC_CLEAR;
            sleep_reg <= 1'b0;
        end
        else
        begin
            to_reg    <= to_next;
            pd_reg    <= pd_next;
            wdt_reg   <= wdt_next;
            presc_reg <= presc_next;
            sleep_reg <= sleep_next;
        end
    end

    // ======================================================================
    // outputs
    // ======================================================================
    assign acc                   = acc_reg;
    assign flags                 = flags_reg;
    assign file_wr               = fwr_reg;
    assign port_a_direction      = g_dir[0].dir_reg;
    assign port_b_direction      = g_dir[1].dir_reg;
    assign port_c_direction      = g_dir[2].dir_reg;
    assign timeout_status_flag   = to_reg;
    assign powerdown_status_flag = pd_reg;
    assign watchdog_counter      = wdt_reg;
    assign watchdog_prescaler    = presc_reg;
    assign sleep_active          = sleep_reg;

endmodule : ssx_exec

// *** tb/ssx_exec_chk.sv ***
// checker: concurrent properties on the exec datapath ports
`timescale 1ns/10ps
module ssx_exec_chk
    import ssx_pkg::*;
(
    // clock and reset
    input wire logic           clk,
    input wire logic           rst_b,
    // inputs
    input ssx_pkg::ssx_instr_t instr,
    input wire logic [7:0]     file_rdata,
    input wire logic           wake,
    // outputs
    input ssx_pkg::ssx_fwrite_t file_wr,
    input wire logic [7:0]     acc,
    input ssx_pkg::ssx_flags_t flags,
    input wire logic [7:0]     port_a_direction,
    input wire logic [7:0]     port_b_direction,
    input wire logic           timeout_status_flag,
    input wire logic           powerdown_status_flag,
    input wire logic [7:0]     watchdog_counter,
    input wire logic [7:0]     watchdog_prescaler,
    input wire logic           sleep_active
);
    import ssx_pkg::*;
    // ====================
    // helpers
    logic tk;
    assign tk = instr.valid && !sleep_active;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // ====================
    // properties
    a_imm_sub_result: assert property (
        tk && instr.op == SSX_OP_SUB_IMM |=> acc == $past(instr.imm) - $past(acc))
        else $error("sub imm result wrong");
    a_sub_flags_set: assert property (
        tk && instr.op == SSX_OP_SUB_IMM |=> flags.carry == ($past(acc) <= $past(instr.imm))
        && flags.digit_carry == ($past(acc[3:0]) <= $past(instr.imm[3:0]))
        && flags.zero == (acc == 8'h00))
        else $error("sub flags wrong");
    a_reg_dest_write: assert property (
        tk && instr.op == SSX_OP_SUB_REG && instr.dest == DEST_REG |=> file_wr.we
        && file_wr.addr == $past(instr.addr) && acc == $past(acc)
        && file_wr.data == $past(file_rdata) - $past(acc))
        else $error("sub reg write-back wrong");
    a_borrow_sub: assert property (
        tk && instr.op == SSX_OP_SUB_REG_BRW && instr.dest == DEST_ACC
        |=> acc == $past(file_rdata) - $past(acc) - {7'h00, ~$past(flags.carry)})
        else $error("borrow sub wrong");
    a_sleep_entry: assert property (
        tk && instr.op == SSX_OP_SLEEP |=> sleep_active && timeout_status_flag
        && !powerdown_status_flag && watchdog_counter == 8'h00 && watchdog_prescaler == 8'h00)
        else $error("sleep entry wrong");
    a_sleep_freeze: assert property (
        sleep_active |=> $stable(acc) && $stable(flags) && $stable(port_b_direction))
        else $error("state moved in sleep");
    a_wake_exit: assert property (sleep_active && wake |=> !sleep_active)
        else $error("wake ignored");
    a_swap_halves: assert property (
        tk && instr.op == SSX_OP_NIBBLE_EXCH && instr.dest == DEST_ACC
        |=> acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && $stable(flags))
        else $error("nibble exchange wrong");
    a_dir_a_cause: assert property (
        $changed(port_a_direction) |-> port_a_direction == $past(acc)
        && $past(tk && instr.op == SSX_OP_LOAD_DIR && instr.addr == 7'h05))
        else $error("port a direction moved");
    a_xor_imm_only: assert property (
        tk && instr.op == SSX_OP_XOR_IMM |=> acc == ($past(acc) ^ $past(instr.imm))
        && flags.zero == (acc == 8'h00) && flags.carry == $past(flags.carry))
        else $error("xor imm wrong");
    a_xor_reg_write: assert property (
        tk && instr.op == SSX_OP_XOR_REG && instr.dest == DEST_REG |=> file_wr.we
        && file_wr.data == ($past(acc) ^ $past(file_rdata)) && acc == $past(acc))
        else $error("xor reg wrong");
endmodule : ssx_exec_chk

bind ssx_exec ssx_exec_chk chk_u (.clk(clk), .rst_b(rst_b), .instr(instr),
    .file_rdata(file_rdata), .wake(wake), .file_wr(file_wr), .acc(acc), .flags(flags),
    .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
    .timeout_status_flag(timeout_status_flag), .powerdown_status_flag(powerdown_status_flag),
    .watchdog_counter(watchdog_counter), .watchdog_prescaler(watchdog_prescaler),
    .sleep_active(sleep_active));

// *** tb/test_subtract_swap_xor_exec.sv ***
// testbench: directed scenarios for the exec datapath
`timescale 1ns/10ps
module test_subtract_swap_xor_exec;
    import ssx_pkg::*;
    // ====================
    // signals and model state
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    ssx_instr_t  instr = '0;
    logic [7:0]  file_rdata = 8'h00;
    logic        wake = 1'b0;
    ssx_fwrite_t file_wr, m_wr;
    ssx_flags_t  flags;
    logic [7:0]  acc, pa, pb, pc, wdt, presc, m_acc, m_dir[3];
    logic        tos, pds, slp, m_c, m_dc, m_z, m_slp, m_pd;
    int          err_total = 0;
    int          cmp_count = 0;
    always #10 clk = ~clk;
    ssx_exec dut_u (.clk(clk), .rst_b(rst_b), .instr(instr), .file_rdata(file_rdata),
        .wake(wake), .file_wr(file_wr), .acc(acc), .flags(flags), .port_a_direction(pa),
        .port_b_direction(pb), .port_c_direction(pc), .timeout_status_flag(tos),
        .powerdown_status_flag(pds), .watchdog_counter(wdt), .watchdog_prescaler(presc),
        .sleep_active(slp));
    // ====================
    // shared tasks
    task automatic chk(string what, logic [23:0] seen, logic [23:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // returns {carry, digit carry, difference}; carry is the inverse of borrow
    function automatic logic [9:0] sub_f(logic [7:0] m, logic [7:0] s, logic b);
        logic [8:0] t;
        logic [4:0] n;
        t = {1'b0, m} - {1'b0, s} - {8'h00, b};
        n = {1'b0, m[3:0]} - {1'b0, s[3:0]} - {4'h0, b};
        return {~t[8], ~n[4], t[7:0]};
    endfunction : sub_f
    // drives one instruction and advances the model; sleeping core takes nothing
    task automatic issue(ssx_op_t op, logic [7:0] k, logic [6:0] a, logic d, logic [7:0] f);
        logic [9:0] s;
        logic [7:0] r;
        @(posedge clk);
        instr <= '{1'b1, op, k, a, d};
        file_rdata <= f;
        m_wr = '0;
        if (m_slp)
            return;
        s = (op == SSX_OP_SUB_IMM) ? sub_f(k, m_acc, 1'b0) :
            sub_f(f, m_acc, (op == SSX_OP_SUB_REG_BRW) ? ~m_c : 1'b0);
        case (op)
            SSX_OP_SUB_IMM, SSX_OP_SUB_REG, SSX_OP_SUB_REG_BRW: r = s[7:0];
            SSX_OP_NIBBLE_EXCH: r = {f[3:0], f[7:4]};
            SSX_OP_XOR_IMM: r = m_acc ^ k;
            SSX_OP_XOR_REG: r = m_acc ^ f;
            default: r = m_acc;
        endcase
        if (op inside {SSX_OP_SUB_IMM, SSX_OP_SUB_REG, SSX_OP_SUB_REG_BRW})
            {m_c, m_dc} = s[9:8];
        if (op inside {SSX_OP_SUB_IMM, SSX_OP_SUB_REG, SSX_OP_SUB_REG_BRW,
            SSX_OP_XOR_IMM, SSX_OP_XOR_REG})
            m_z = (r == 8'h00);
        if (op == SSX_OP_LOAD_DIR && a inside {[7'h05:7'h07]})
            m_dir[a - 7'h05] = m_acc;
        if (op == SSX_OP_SLEEP)
            {m_slp, m_pd} = 2'b10;
        if (op inside {SSX_OP_SUB_REG, SSX_OP_SUB_REG_BRW, SSX_OP_NIBBLE_EXCH,
            SSX_OP_XOR_REG} && d == DEST_REG)
            m_wr = '{1'b1, a, r};
        else
            m_acc = r;
    endtask : issue
    task automatic settle();
        @(posedge clk);
        instr.valid <= 1'b0;
        #1;
        chk("acc", 24'(acc), 24'(m_acc));
        chk("flags", 24'(flags), 24'({m_c, m_dc, m_z}));
        chk("file_wr", 24'(file_wr), 24'(m_wr));
        chk("dirs", {pa, pb, pc}, {m_dir[0], m_dir[1], m_dir[2]});
        chk("status", 24'({tos, pds, slp}), 24'({1'b1, m_pd, m_slp}));
    endtask : settle
    // ====================
    // scenarios
    task automatic t_sub();
        logic [15:0] tab[6] = '{16'h0503, 16'h0305, 16'h4242, 16'h1821, 16'h00FF, 16'hFF00};
        foreach (tab[i])
        begin
            issue(SSX_OP_XOR_IMM, m_acc ^ tab[i][15:8], 7'h00, DEST_ACC, 8'h00);
            settle();
            issue(SSX_OP_SUB_IMM, tab[i][7:0], 7'h00, DEST_ACC, 8'h00);
            settle();
        end
        $display("subtract immediate done");
    endtask : t_sub
    task automatic t_reg();
        issue(SSX_OP_SUB_REG, 8'h00, 7'h7F, DEST_REG, 8'h10);
        settle();
        issue(SSX_OP_SUB_REG, 8'h00, 7'h00, DEST_ACC, 8'h01);
        settle();
        issue(SSX_OP_SUB_REG_BRW, 8'h00, 7'h22, DEST_ACC, 8'h80);
        settle();
        // back to back: the borrow form must see the carry just written
        issue(SSX_OP_SUB_IMM, 8'h00, 7'h00, DEST_ACC, 8'h00);
        issue(SSX_OP_SUB_REG_BRW, 8'h00, 7'h31, DEST_REG, 8'h40);
        settle();
        $display("subtract register done");
    endtask : t_reg
    task automatic t_misc();
        issue(SSX_OP_NIBBLE_EXCH, 8'h00, 7'h10, DEST_ACC, 8'hA5);
        settle();
        issue(SSX_OP_NIBBLE_EXCH, 8'h00, 7'h11, DEST_REG, 8'h3C);
        settle();
        issue(SSX_OP_XOR_IMM, m_acc, 7'h00, DEST_ACC, 8'h00);
        settle();
        issue(SSX_OP_XOR_REG, 8'h00, 7'h05, DEST_REG, 8'h96);
        settle();
        issue(SSX_OP_XOR_REG, 8'h00, 7'h05, DEST_ACC, 8'h69);
        settle();
        for (int a = 4; a < 9; a++)
        begin
            issue(SSX_OP_XOR_IMM, m_acc ^ (8'h11 * 8'(a)), 7'h00, DEST_ACC, 8'h00);
            issue(SSX_OP_LOAD_DIR, 8'h00, 7'(a), DEST_ACC, 8'h00);
            settle();
        end
        // low bits select port a but upper bits set: nothing loads
        issue(SSX_OP_LOAD_DIR, 8'h00, 7'h0D, DEST_ACC, 8'h00);
        settle();
        $display("swap xor direction done");
    endtask : t_misc
    task automatic t_sleep();
        issue(SSX_OP_SLEEP, 8'h00, 7'h00, DEST_ACC, 8'h00);
        settle();
        chk("watchdog", 24'({wdt, presc}), 24'h000000);
        issue(SSX_OP_XOR_IMM, 8'h5A, 7'h00, DEST_ACC, 8'h00);
        settle();
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        #1;
        m_slp = 1'b0;
        chk("sleep", 24'(slp), 24'(m_slp));
        $display("sleep done");
    endtask : t_sleep
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    // ====================
    // main sequence and hang limit
    initial
    begin
        {m_acc, m_c, m_dc, m_z, m_slp, m_pd, m_wr} = {ACC_RST, 4'h0, PD_RST, 16'h0000};
        m_dir = '{DIR_RST, DIR_RST, DIR_RST};
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        settle();
        t_sub();
        t_reg();
        t_misc();
        t_sleep();
        summarize();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        err_total++;
        summarize();
    end
endmodule : test_subtract_swap_xor_exec
